// ===== ddf_pkg.sv
`default_nettype none

package ddf_pkg;

    // storage geometry, 64K build (32K build: DDF_ADDR_W = 15)
    localparam int DDF_ADDR_W = 16;
    localparam int DDF_PTR_W = DDF_ADDR_W + 1;
    localparam int DDF_DATA_W = 18;
    localparam int DDF_THR_W = 16;
    localparam int DDF_STAGE_DEPTH = 32;
    localparam logic [DDF_PTR_W-1:0] DDF_DEPTH_WORDS = 17'h10000;
    localparam logic [DDF_PTR_W-1:0] DDF_PTR_ZERO = 17'h00000;
    localparam logic [DDF_PTR_W-1:0] DDF_PTR_ONE = 17'h00001;

    // threshold reset value
    localparam logic [DDF_THR_W-1:0] DDF_THR_DEFAULT = 16'h007F;
    localparam logic [DDF_DATA_W-1:0] DDF_DATA_ZERO = 18'h00000;

    typedef enum logic {DDF_SEL_EMPTY, DDF_SEL_FULL} ddf_thr_sel_t;

    function automatic logic [DDF_PTR_W-1:0] ddf_bin2gray(input logic [DDF_PTR_W-1:0] b);
        ddf_bin2gray = b ^ (b >> 1);
    endfunction : ddf_bin2gray

    function automatic logic [DDF_PTR_W-1:0] ddf_gray2bin(input logic [DDF_PTR_W-1:0] g);
        logic [DDF_PTR_W-1:0] b;
        b = g;
        for (int i = DDF_PTR_W - 2; i >= 0; i--)
        begin
            b[i] = b[i+1] ^ g[i];
        end
        ddf_gray2bin = b;
    endfunction : ddf_gray2bin

    // occupancy seen from a pair of pointers
    function automatic logic [DDF_PTR_W-1:0] ddf_count(input logic [DDF_PTR_W-1:0] wp,
                                                       input logic [DDF_PTR_W-1:0] rp);
        ddf_count = wp - rp;
    endfunction : ddf_count

    function automatic logic [DDF_PTR_W-1:0] ddf_thr_ext(input logic [DDF_THR_W-1:0] t);
        ddf_thr_ext = {{(DDF_PTR_W-DDF_THR_W){1'b0}}, t};
    endfunction : ddf_thr_ext

endpackage : ddf_pkg

`default_nettype wire

// ===== ddf_fifo.sv
`default_nettype none

module ddf_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
    localparam logic [AW-1:0] PTR_ONE = AW'(1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] cnt_ff;
    logic out_valid_ff;
    logic [WIDTH-1:0] out_data_ff;
    logic push;
    logic pop_mem;

    assign in_ready_o = (cnt_ff != FULL_CNT);
    assign push = in_valid_i && in_ready_o;
    // refill the output register only when it is free or being taken
    assign pop_mem = (cnt_ff != '0) && (!out_valid_ff || out_ready_i);
    assign out_valid_o = out_valid_ff;
    assign out_data_o = out_data_ff;

    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= wr_ptr_ff + PTR_ONE;
            end
            if (pop_mem)
            begin
                rd_ptr_ff <= rd_ptr_ff + PTR_ONE;
            end
            if (push && !pop_mem)
            begin
                cnt_ff <= cnt_ff + CNT_ONE;
            end
            else if (!push && pop_mem)
            begin
                cnt_ff <= cnt_ff - CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            out_valid_ff <= 1'b0;
            out_data_ff <= '0;
        end
        else if (pop_mem)
        begin
            out_valid_ff <= 1'b1;
            out_data_ff <= mem_ff[rd_ptr_ff];
        end
        else if (out_ready_i)
        begin
            out_valid_ff <= 1'b0;
        end
    end

endmodule : ddf_fifo

`default_nettype wire

// ===== ddf_top.sv
// Behaviour
// - store 64K (or 32K) words of 18 bits with separate read and write pointers
// - full flag may release one write edge late when read edge is close
// - empty flag may release late when a write edge is close before a read
// - device reset empties the store and drives the empty flag low
// - during device reset the output word goes low, seen only with output enabled
// - write enable low stores one input word per write clock rising edge
// - read enable low presents the next stored word per read clock edge
// - outputs released when output enable high, driven from output register when low
// - in cascade mode only the read-enabled device drives the outputs
// - writes while full and reads while empty change nothing
// - when empty the last validly read word stays on the outputs
// - two 16-bit thresholds loaded from data bits 15..0 set almost flags
// - load and write low write empty threshold, then full, cycling
// - programming may stop anywhere; next programming write continues the sequence
// - load and read low output the thresholds in the same cycling order
// - full flag low when full, blocks writes, updates only on write edges
// - empty flag low when empty, blocks reads, updates only on read edges
// - almost empty within empty threshold of empty, almost full within full threshold
// - sync flag select low: almost full on write edges, almost empty on read edges
// - in sync mode an almost flag may change one own edge late
// - flags follow pointers during retransmit and are valid one edge later
// - both thresholds default to 127 words
// - retransmit pulse returns the read pointer to the first location
`default_nettype none

module ddf_top
    import ddf_pkg::*;
(
    // system clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // write side pins
    input wire logic wclk_i,
    input wire logic write_n_i,
    input wire logic [DDF_DATA_W-1:0] data_i,
    input wire logic load_select_n_i,
    // read side pins
    input wire logic rclk_i,
    input wire logic read_n_i,
    input wire logic output_enable_n_i,
    input wire logic cascade_en_i,
    // control pins
    input wire logic reset_n_i,
    input wire logic retransmit_pulse_i,
    input wire logic sync_flag_select_i,
    // data outputs
    output logic [DDF_DATA_W-1:0] q_o,
    output logic q_oe_o,
    // flags
    output logic full_flag_n_o,
    output logic empty_flag_n_o,
    output logic almost_empty_n_o,
    output logic almost_full_n_o
);

    localparam int PIN_W = 10 + DDF_DATA_W;

    // pin synchronisers
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] sync1_ff;
    logic [PIN_W-1:0] sync2_ff;
    logic wclk_s;
    logic rclk_s;
    logic write_n_s;
    logic read_n_s;
    logic load_n_s;
    logic oe_n_s;
    logic reset_n_s;
    logic rt_s;
    logic sync_sel_s;
    logic cascade_s;
    logic [DDF_DATA_W-1:0] din_s;
    logic wclk_d_ff;
    logic rclk_d_ff;
    logic rt_d_ff;

    // events
    logic dev_rst;
    logic wr_edge;
    logic rd_edge;
    logic rt_rise;
    logic wr_prog;
    logic wr_try;
    logic wr_take;
    logic rd_reg;
    logic rd_try;
    logic rd_take;

    // pointers and crossings
    logic [DDF_PTR_W-1:0] wptr_ff;
    logic [DDF_PTR_W-1:0] nxt_wptr;
    logic [DDF_PTR_W-1:0] commit_ptr_ff;
    logic [DDF_PTR_W-1:0] rptr_ff;
    logic [DDF_PTR_W-1:0] nxt_rptr;
    logic [DDF_PTR_W-1:0] wgray_ff;
    logic [DDF_PTR_W-1:0] wgray_s1_ff;
    logic [DDF_PTR_W-1:0] wgray_s2_ff;
    logic [DDF_PTR_W-1:0] rgray_ff;
    logic [DDF_PTR_W-1:0] rgray_s1_ff;
    logic [DDF_PTR_W-1:0] rgray_s2_ff;
    logic [DDF_PTR_W-1:0] wbin_rs;
    logic [DDF_PTR_W-1:0] rbin_ws;

    // staging buffer
    logic stage_in_ready;
    logic stage_out_valid;
    logic stage_out_ready;
    logic [DDF_DATA_W-1:0] stage_out_data;
    logic stage_rst;
    logic drain;

    // storage, thresholds, outputs
    logic [DDF_DATA_W-1:0] store_mem [2**DDF_ADDR_W];
    logic [DDF_THR_W-1:0] empty_thr_ff;
    logic [DDF_THR_W-1:0] full_thr_ff;
    ddf_thr_sel_t wsel_ff;
    ddf_thr_sel_t rsel_ff;
    logic [DDF_DATA_W-1:0] q_ff;
    logic q_oe_ff;
    logic full_flag_n_ff;
    logic empty_flag_n_ff;
    logic almost_empty_n_ff;
    logic almost_full_n_ff;
    logic [DDF_PTR_W-1:0] rd_cnt_now;
    logic [DDF_PTR_W-1:0] rd_cnt_nxt;
    logic [DDF_PTR_W-1:0] wr_cnt_now;
    logic [DDF_PTR_W-1:0] wr_cnt_nxt;
    logic [DDF_PTR_W-1:0] af_level;

    assign pin_raw = {wclk_i, rclk_i, write_n_i, read_n_i, load_select_n_i, output_enable_n_i,
                      reset_n_i, retransmit_pulse_i, sync_flag_select_i, cascade_en_i, data_i};
    assign {wclk_s, rclk_s, write_n_s, read_n_s, load_n_s, oe_n_s,
            reset_n_s, rt_s, sync_sel_s, cascade_s, din_s} = sync2_ff;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end
        else
        begin
            sync1_ff <= pin_raw;
            sync2_ff <= sync1_ff;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wclk_d_ff <= 1'b0;
            rclk_d_ff <= 1'b0;
            rt_d_ff <= 1'b0;
        end
        else
        begin
            wclk_d_ff <= wclk_s;
            rclk_d_ff <= rclk_s;
            rt_d_ff <= rt_s;
        end
    end

    assign dev_rst = !reset_n_s;
    assign wr_edge = wclk_s && !wclk_d_ff;
    assign rd_edge = rclk_s && !rclk_d_ff;
    assign rt_rise = rt_s && !rt_d_ff;
    assign wr_prog = wr_edge && !load_n_s && !write_n_s;
    assign wr_try = wr_edge && load_n_s && !write_n_s;
    // full flag and a stalled stage both refuse the word
    assign wr_take = wr_try && full_flag_n_ff && stage_in_ready;
    assign rd_reg = rd_edge && !load_n_s && !read_n_s;
    assign rd_try = rd_edge && load_n_s && !read_n_s;
    assign rd_take = rd_try && empty_flag_n_ff && !rt_rise;

    // gray crossings: each side compares against a pointer three stages old
    assign wbin_rs = ddf_gray2bin(wgray_s2_ff);
    assign rbin_ws = ddf_gray2bin(rgray_s2_ff);

    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            wgray_ff <= '0;
            wgray_s1_ff <= '0;
            wgray_s2_ff <= '0;
            rgray_ff <= '0;
            rgray_s1_ff <= '0;
            rgray_s2_ff <= '0;
        end
        else
        begin
            wgray_ff <= ddf_bin2gray(commit_ptr_ff);
            wgray_s1_ff <= wgray_ff;
            wgray_s2_ff <= wgray_s1_ff;
            rgray_ff <= ddf_bin2gray(rptr_ff);
            rgray_s1_ff <= rgray_ff;
            rgray_s2_ff <= rgray_s1_ff;
        end
    end

    // write pointer counts accepted words, staged ones included
    assign nxt_wptr = wr_take ? wptr_ff + DDF_PTR_ONE : wptr_ff;

    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            wptr_ff <= DDF_PTR_ZERO;
        end
        else
        begin
            wptr_ff <= nxt_wptr;
        end
    end

    // drain pauses during a retransmit pulse, the stage absorbs writes meanwhile
    assign stage_rst = reset_i || dev_rst;
    assign stage_out_ready = !rt_s;
    assign drain = stage_out_valid && stage_out_ready;

    ddf_fifo #(
        .WIDTH(DDF_DATA_W),
        .DEPTH(DDF_STAGE_DEPTH)
    ) u_stage (
        .clk_i(clk_i),
        .reset_i(stage_rst),
        .in_valid_i(wr_take),
        .in_ready_o(stage_in_ready),
        .in_data_i(din_s),
        .out_valid_o(stage_out_valid),
        .out_ready_i(stage_out_ready),
        .out_data_o(stage_out_data)
    );

    always_ff @(posedge clk_i)
    begin
        if (drain)
        begin
            store_mem[commit_ptr_ff[DDF_ADDR_W-1:0]] <= stage_out_data;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            commit_ptr_ff <= DDF_PTR_ZERO;
        end
        else if (drain)
        begin
            commit_ptr_ff <= commit_ptr_ff + DDF_PTR_ONE;
        end
    end

    // retransmit wins over a read on the same edge
    assign nxt_rptr = rt_rise ? DDF_PTR_ZERO : (rd_take ? rptr_ff + DDF_PTR_ONE : rptr_ff);

    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            rptr_ff <= DDF_PTR_ZERO;
        end
        else
        begin
            rptr_ff <= nxt_rptr;
        end
    end

    // threshold programming, select survives a pause in load
    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            empty_thr_ff <= DDF_THR_DEFAULT;
            full_thr_ff <= DDF_THR_DEFAULT;
            wsel_ff <= DDF_SEL_EMPTY;
        end
        else if (wr_prog)
        begin
            if (wsel_ff == DDF_SEL_EMPTY)
            begin
                empty_thr_ff <= din_s[DDF_THR_W-1:0];
                wsel_ff <= DDF_SEL_FULL;
            end
            else
            begin
                full_thr_ff <= din_s[DDF_THR_W-1:0];
                wsel_ff <= DDF_SEL_EMPTY;
            end
        end
    end

    // output register: read data, threshold readback, held when refused
    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            q_ff <= DDF_DATA_ZERO;
            rsel_ff <= DDF_SEL_EMPTY;
        end
        else if (rd_reg)
        begin
            if (rsel_ff == DDF_SEL_EMPTY)
            begin
                q_ff <= {{(DDF_DATA_W-DDF_THR_W){1'b0}}, empty_thr_ff};
                rsel_ff <= DDF_SEL_FULL;
            end
            else
            begin
                q_ff <= {{(DDF_DATA_W-DDF_THR_W){1'b0}}, full_thr_ff};
                rsel_ff <= DDF_SEL_EMPTY;
            end
        end
        else if (rd_take)
        begin
            q_ff <= store_mem[rptr_ff[DDF_ADDR_W-1:0]];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            q_oe_ff <= 1'b0;
        end
        else
        begin
            q_oe_ff <= !oe_n_s && (!cascade_s || !read_n_s);
        end
    end

    // occupancy from each side's view
    assign rd_cnt_now = ddf_count(wbin_rs, rptr_ff);
    assign rd_cnt_nxt = ddf_count(wbin_rs, nxt_rptr);
    assign wr_cnt_now = ddf_count(wptr_ff, rbin_ws);
    assign wr_cnt_nxt = ddf_count(nxt_wptr, rbin_ws);
    assign af_level = DDF_DEPTH_WORDS - ddf_thr_ext(full_thr_ff);

    // stale synced pointers only delay a release, never a set
    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            full_flag_n_ff <= 1'b1;
        end
        else if (wr_edge)
        begin
            full_flag_n_ff <= (wr_cnt_nxt != DDF_DEPTH_WORDS);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            empty_flag_n_ff <= 1'b0;
        end
        else if (rd_edge)
        begin
            empty_flag_n_ff <= (rd_cnt_nxt != DDF_PTR_ZERO);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            almost_empty_n_ff <= 1'b0;
        end
        else if (!sync_sel_s)
        begin
            if (rd_edge)
            begin
                almost_empty_n_ff <= !(rd_cnt_nxt <= ddf_thr_ext(empty_thr_ff));
            end
        end
        else
        begin
            almost_empty_n_ff <= !(rd_cnt_now <= ddf_thr_ext(empty_thr_ff));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i || dev_rst)
        begin
            almost_full_n_ff <= 1'b1;
        end
        else if (!sync_sel_s)
        begin
            if (wr_edge)
            begin
                almost_full_n_ff <= !(wr_cnt_nxt >= af_level);
            end
        end
        else
        begin
            almost_full_n_ff <= !(wr_cnt_now >= af_level);
        end
    end

    assign q_o = q_ff;
    assign q_oe_o = q_oe_ff;
    assign full_flag_n_o = full_flag_n_ff;
    assign empty_flag_n_o = empty_flag_n_ff;
    assign almost_empty_n_o = almost_empty_n_ff;
    assign almost_full_n_o = almost_full_n_ff;

    sequence prog_empty_s;
        wr_prog && !dev_rst && (wsel_ff == DDF_SEL_EMPTY);
    endsequence

    sequence prog_full_s;
        wr_prog && !dev_rst && (wsel_ff == DDF_SEL_FULL);
    endsequence

    reset_empty_a: assert property (@(posedge clk_i) disable iff (reset_i)
        dev_rst |=> !empty_flag_n_o && full_flag_n_o && (q_o == DDF_DATA_ZERO))
        else $error("device reset did not empty the store");

    write_store_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_take && !dev_rst) |=> (wptr_ff == $past(wptr_ff) + DDF_PTR_ONE))
        else $error("accepted write did not advance the write pointer");

    full_block_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (wr_try && !full_flag_n_o && !dev_rst) |=> (wptr_ff == $past(wptr_ff)))
        else $error("write accepted while full");

    empty_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rd_try && !empty_flag_n_o && !dev_rst && !rt_rise)
            |=> (rptr_ff == $past(rptr_ff)) && (q_o == $past(q_o)))
        else $error("read changed state while empty");

    full_flag_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!wr_edge && !dev_rst) |=> $stable(full_flag_n_o))
        else $error("full flag moved without a write edge");

    empty_flag_edge_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!rd_edge && !dev_rst) |=> $stable(empty_flag_n_o))
        else $error("empty flag moved without a read edge");

    thr_cycle_a: assert property (@(posedge clk_i) disable iff (reset_i)
        prog_empty_s |=> (empty_thr_ff == $past(din_s[DDF_THR_W-1:0]))
            && (wsel_ff == DDF_SEL_FULL))
        else $error("empty threshold not written first");

    thr_full_a: assert property (@(posedge clk_i) disable iff (reset_i)
        prog_full_s |=> (full_thr_ff == $past(din_s[DDF_THR_W-1:0]))
            && (wsel_ff == DDF_SEL_EMPTY) && $stable(empty_thr_ff))
        else $error("full threshold write out of sequence");

    retransmit_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (rt_rise && !dev_rst) |=> (rptr_ff == DDF_PTR_ZERO))
        else $error("retransmit did not rewind the read pointer");

    oe_release_a: assert property (@(posedge clk_i) disable iff (reset_i)
        oe_n_s |=> !q_oe_o)
        else $error("outputs driven with output enable high");

    af_sync_a: assert property (@(posedge clk_i) disable iff (reset_i)
        (!sync_sel_s && !wr_edge && !dev_rst) |=> $stable(almost_full_n_o))
        else $error("sync almost full moved without a write edge");

endmodule : ddf_top

`default_nettype wire

// ===== ddf_partner.sv
`default_nettype none

module ddf_partner
    import ddf_pkg::*;
(
    // system clock
    input wire logic clk_i,
    // producer side
    output logic wclk_o,
    output logic write_n_o,
    output logic load_select_n_o,
    output logic [DDF_DATA_W-1:0] data_o,
    // consumer side
    output logic rclk_o,
    output logic read_n_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // clocks stand low and enables idle while the device resets
    initial
    begin
        wclk_o = 1'b0;
        rclk_o = 1'b0;
        write_n_o = 1'b1;
        read_n_o = 1'b1;
        load_select_n_o = 1'b1;
        data_o = 18'h00000;
    end

    // high phase of 3 clk and low phase of 2 clk keep the 2-flop sampling margin
    task automatic edge_pulse(input logic rd);
        @(negedge clk_i);
        if (rd)
            rclk_o = 1'b1;
        else
            wclk_o = 1'b1;
        repeat (3) @(negedge clk_i);
        rclk_o = 1'b0;
        wclk_o = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : edge_pulse

    task automatic wr(input logic [DDF_DATA_W-1:0] d, input logic ld_n);
        @(negedge clk_i);
        data_o = d;
        write_n_o = 1'b0;
        load_select_n_o = ld_n;
        edge_pulse(1'b0);
        write_n_o = 1'b1;
        load_select_n_o = 1'b1;
        // released data must not look like the last word
        data_o = ~d;
    endtask : wr

    task automatic rd(input logic ld_n);
        @(negedge clk_i);
        read_n_o = 1'b0;
        load_select_n_o = ld_n;
        edge_pulse(1'b1);
        read_n_o = 1'b1;
        load_select_n_o = 1'b1;
    endtask : rd
endmodule : ddf_partner

`default_nettype wire

// ===== tb_dual_clock_deep_fifo_flags.sv
`default_nettype none

`define CHK(got, exp) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
        end \
    end

module tb_dual_clock_deep_fifo_flags
    import ddf_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic clk_i, reset_i, reset_n_i, oe_n_i, cascade_en_i, rt_i, sync_sel_i;
    logic wclk, write_n, load_n, rclk, read_n;
    logic [DDF_DATA_W-1:0] data, q_o;
    logic q_oe_o, full_flag_n_o, empty_flag_n_o, almost_empty_n_o, almost_full_n_o;
    wire [DDF_DATA_W-1:0] q_pin;
    int failures = 0;
    int num_checks = 0;
    logic [DDF_DATA_W-1:0] words [4] = '{18'h3C001, 18'h0C3A2, 18'h2F0F3, 18'h15554};

    assign q_pin = q_oe_o ? q_o : 'z;

    ddf_partner ddf_partner_inst (.clk_i(clk_i), .wclk_o(wclk), .write_n_o(write_n),
        .load_select_n_o(load_n), .data_o(data), .rclk_o(rclk), .read_n_o(read_n));

    ddf_top ddf_top_inst (.clk_i(clk_i), .reset_i(reset_i), .wclk_i(wclk),
        .write_n_i(write_n), .data_i(data), .load_select_n_i(load_n), .rclk_i(rclk),
        .read_n_i(read_n), .output_enable_n_i(oe_n_i), .cascade_en_i(cascade_en_i),
        .reset_n_i(reset_n_i), .retransmit_pulse_i(rt_i), .sync_flag_select_i(sync_sel_i),
        .q_o(q_o), .q_oe_o(q_oe_o), .full_flag_n_o(full_flag_n_o),
        .empty_flag_n_o(empty_flag_n_o), .almost_empty_n_o(almost_empty_n_o),
        .almost_full_n_o(almost_full_n_o));

    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic results();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic dev_reset();
        reset_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        `CHK(q_pin, 18'h00000)
        `CHK({empty_flag_n_o, almost_empty_n_o, full_flag_n_o}, 3'h1)
        reset_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask : dev_reset

    // whole sequence needs well under 1000 clk cycles
    initial
    begin
        #150us;
        failures++;
        results();
    end

    initial
    begin
        reset_i = 1'b1;
        reset_n_i = 1'b1;
        oe_n_i = 1'b0;
        cascade_en_i = 1'b0;
        rt_i = 1'b0;
        sync_sel_i = 1'b0;
        repeat (8) @(negedge clk_i);
        reset_i = 1'b0;
        repeat (3) @(negedge clk_i);
        dev_reset();
        for (int i = 0; i < 2; i++)
        begin
            ddf_partner_inst.rd(1'b0);
            `CHK(q_pin, 18'h0007F)
        end
        ddf_partner_inst.wr(18'h30002, 1'b0);
        ddf_partner_inst.wr(18'h30005, 1'b0);
        ddf_partner_inst.wr(18'h30003, 1'b0);
        ddf_partner_inst.wr(18'h30006, 1'b0);
        ddf_partner_inst.rd(1'b0);
        `CHK(q_pin, 18'h00003)
        ddf_partner_inst.rd(1'b0);
        `CHK(q_pin, 18'h00006)
        $display("threshold test done");
        for (int i = 0; i < 4; i++)
            ddf_partner_inst.wr(words[i], 1'b1);
        repeat (12) @(negedge clk_i);
        ddf_partner_inst.rd(1'b1);
        `CHK({empty_flag_n_o, almost_empty_n_o, almost_full_n_o}, 3'h7)
        for (int i = 0; i < 4; i++)
        begin
            ddf_partner_inst.rd(1'b1);
            `CHK(q_pin, words[i])
            if (i == 0)
                `CHK(almost_empty_n_o, 1'b0)
        end
        `CHK(empty_flag_n_o, 1'b0)
        ddf_partner_inst.rd(1'b1);
        `CHK(q_pin, words[3])
        $display("data test done");
        rt_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rt_i = 1'b0;
        repeat (6) @(negedge clk_i);
        ddf_partner_inst.rd(1'b1);
        ddf_partner_inst.rd(1'b1);
        `CHK(q_pin, words[0])
        $display("retransmit test done");
        oe_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK(q_oe_o, 1'b0)
        oe_n_i = 1'b0;
        cascade_en_i = 1'b1;
        repeat (4) @(negedge clk_i);
        `CHK(q_oe_o, 1'b0)
        ddf_partner_inst.read_n_o = 1'b0;
        repeat (4) @(negedge clk_i);
        `CHK(q_pin, words[0])
        ddf_partner_inst.read_n_o = 1'b1;
        cascade_en_i = 1'b0;
        repeat (4) @(negedge clk_i);
        $display("output enable test done");
        dev_reset();
        ddf_partner_inst.rd(1'b0);
        `CHK(q_pin, 18'h0007F)
        $display("second reset test done");
        // free-running flags: almost full trips at two words with full threshold FFFE
        sync_sel_i = 1'b1;
        ddf_partner_inst.wr(18'h00001, 1'b0);
        ddf_partner_inst.wr(18'h0FFFE, 1'b0);
        ddf_partner_inst.rd(1'b0);
        `CHK(q_pin, 18'h0FFFE)
        ddf_partner_inst.wr(words[0], 1'b1);
        ddf_partner_inst.wr(words[1], 1'b1);
        repeat (12) @(negedge clk_i);
        `CHK({almost_empty_n_o, almost_full_n_o}, 2'h2)
        ddf_partner_inst.rd(1'b1);
        ddf_partner_inst.rd(1'b1);
        `CHK(q_pin, words[0])
        repeat (6) @(negedge clk_i);
        `CHK({almost_empty_n_o, almost_full_n_o}, 2'h1)
        $display("free-running flag test done");
        results();
    end
endmodule : tb_dual_clock_deep_fifo_flags

`default_nettype wire
